// ### core/pid_sleep_pkg.sv
/*
  Constants, register layouts, reset values and carrier structs for the
  setpoint, sleep and dwell conditioning block.
  Assumes a 20 MHz core clock and an APB master with 32-bit data.
*/
// Notes on behaviour
// - Sleep after output below level past delay
// - Wake after output above level past delay
// - Sleep detector runs even with control off
// - Sleep stop uses selected stopping method
// - Feedback-high flagged after level held for time
// - Setpoint ramped by ramp time; zero means none
// - Bypass input skips the setpoint ramp
// - Source select: external input or internal value
// - Internal setpoint 0 to 100.00 percent, used when selected
// - Monitors scaled as Hz, percent, rpm, user; the reference monitor is not scaled here
// - User scale: full-scale value at max frequency
// - Controller output lower clamp; zero disables it
// - Controller input clamped to plus/minus limit
// - Reference monitor: adjusted or raw reference
// - Trim modes: negative output zero-limited or reversed
// - Start dwell holds frequency for start time
// - Stop dwell holds frequency for stop time
// - Feedback-high level 0 to 100 percent, default 100
package pid_sleep_pkg;

  localparam int CLK_PERIOD_NS    = 50;
  localparam int TICK_PERIOD_NS   = 100_000_000;
  localparam int TICK_CYCLES_DFLT = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int ADDR_W           = 8;

  // Percent in 0.01 %, frequency in 0.1 Hz, times in 0.1 s ticks
  localparam int RAMP_STEP_NUM = 1000;
  localparam int PCT_FULL      = 10000;
  localparam int HZ_DISP_DIV   = 1000;
  localparam int RPM_NUM       = 12;
  localparam int INLIM_SCALE   = 10;

  localparam logic [15:0] LEVEL_MAX  = 16'h0fa0;
  localparam logic [15:0] PCT_MAX    = 16'h2710;
  localparam logic [15:0] UFS_MAX    = 16'hea60;
  localparam logic [15:0] DWELL_MAX  = 16'h0064;

  localparam logic [ADDR_W-1:0] A_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] A_SLEEP   = 8'h04;
  localparam logic [ADDR_W-1:0] A_FBH     = 8'h08;
  localparam logic [ADDR_W-1:0] A_SP      = 8'h0c;
  localparam logic [ADDR_W-1:0] A_LIM     = 8'h10;
  localparam logic [ADDR_W-1:0] A_SCALE   = 8'h14;
  localparam logic [ADDR_W-1:0] A_DWS     = 8'h18;
  localparam logic [ADDR_W-1:0] A_DWP     = 8'h1c;
  localparam logic [ADDR_W-1:0] A_STATUS  = 8'h20;
  localparam logic [ADDR_W-1:0] A_SP_MON  = 8'h24;
  localparam logic [ADDR_W-1:0] A_REF_MON = 8'h28;
  localparam logic [ADDR_W-1:0] A_FB_MON  = 8'h2c;

  localparam logic [2:0] MODE_OFF    = 3'h0;
  localparam logic [2:0] MODE_TRIM_A = 3'h3;
  localparam logic [2:0] MODE_TRIM_B = 3'h4;
  localparam logic [1:0] SC_HZ       = 2'h0;
  localparam logic [1:0] SC_PCT      = 2'h1;
  localparam logic [1:0] SC_RPM      = 2'h2;
  localparam logic [1:0] SC_USER     = 2'h3;

  typedef struct packed {
    logic [1:0] user_decimal_places;
    logic       trim_negative_reverse_select;
    logic       ref_monitor_content_select;
    logic [1:0] setpoint_scaling_code;
    logic       setpoint_source_select;
    logic       reverse_prohibit_select;
    logic [1:0] stop_method_select;
    logic [2:0] process_control_mode;
  } ctrl_t;
  typedef struct packed {logic [7:0] sleep_delay;        logic [15:0] sleep_level;} sleep_t;
  typedef struct packed {logic [7:0] feedback_high_time; logic [15:0] feedback_high_level;} fbh_t;
  typedef struct packed {logic [15:0] internal_setpoint_value; logic [7:0] setpoint_ramp_time;} sp_t;
  typedef struct packed {logic [15:0] input_bipolar_clamp; logic [15:0] output_lower_clamp;} lim_t;
  typedef struct packed {logic [15:0] max_output_frequency; logic [15:0] user_full_scale_value;} scale_t;
  typedef struct packed {logic [7:0] start_dwell_time; logic [15:0] start_dwell_frequency;} dws_t;
  typedef struct packed {logic [7:0] stop_dwell_time;  logic [15:0] stop_dwell_frequency;} dwp_t;
  typedef struct packed {
    ctrl_t ctrl; sleep_t sleep; fbh_t fbh; sp_t sp; lim_t lim; scale_t scale; dws_t dws; dwp_t dwp;
  } cfg_t;
  typedef struct packed {logic reverse; logic dwell_active; logic fb_high_loss; logic sleeping;} status_t;

  typedef struct packed {
    logic [15:0] freq_ref;
    logic [15:0] ramp_freq;
    logic        accelerating;
    logic        decelerating;
    logic        run_cmd;
  } drive_in_t;
  typedef struct packed {
    logic [15:0] setpoint_ext;
    logic [15:0] feedback;
    logic [15:0] pid_out;
  } pid_in_t;
  typedef struct packed {
    logic [15:0] freq_target;
    logic [15:0] out_freq;
    logic        hold_ramp;
    logic        run_enable;
    logic        reverse;
    logic [1:0]  stop_mode;
  } drive_out_t;
  typedef struct packed {logic [15:0] pid_setpoint; logic [31:0] pid_error;} pid_side_t;

  typedef enum logic [2:0] {DW_IDLE = 3'b001, DW_START = 3'b010, DW_STOP = 3'b100} dwell_st_t;

  localparam cfg_t CFG_RST = '{
    ctrl:  '{trim_negative_reverse_select: 1'h1, setpoint_scaling_code: SC_PCT, default: '0},
    fbh:   '{feedback_high_time: 8'h0a, feedback_high_level: 16'h2710},
    lim:   '{input_bipolar_clamp: 16'h2710, output_lower_clamp: 16'h0000},
    scale: '{max_output_frequency: 16'h0258, user_full_scale_value: 16'h2710},
    default: '0
  };

endpackage

// ### core/hold_timer.sv
/*
  Qualifying delay timer: raises expired once cond has held for longer
  than limit control ticks. Assumes tick is a one-cycle enable.
*/
`timescale 1ns/1ps
module hold_timer #(
  parameter int CNT_W = 9,
  parameter int LIM_W = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             tick,
  input  wire logic             cond,
  input  wire logic [LIM_W-1:0] limit,
  output logic                  expired
);
  if (CNT_W <= LIM_W) begin : g_chk
    $error("hold_timer: CNT_W must exceed LIM_W");
  end

  typedef struct packed {logic [CNT_W-1:0] cnt; logic exp;} tstate_t;
  tstate_t st;
  tstate_t nx;

  always_comb begin
    nx = st;
    if (!cond) begin
      nx.cnt = '0;
    end else if (tick && st.cnt != '1) begin
      nx.cnt = st.cnt + 1'b1;
    end
    // Strictly longer than the limit, so limit 0 still needs one tick
    nx.exp = cond && (nx.cnt > CNT_W'(limit));
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign expired = st.exp;
endmodule

// ### core/pid_sleep_setpoint_dwell.sv
/*
  Setpoint conditioning, sleep detector, feedback-high timing, reference
  adjustment and dwell hold for a drive, with an APB register slave.
  Assumes the controller, ramp generator and setpoint sources share core_clk;
  only the bypass input comes from a pin.
*/
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module pid_sleep_setpoint_dwell
  import pid_sleep_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT,
  parameter int MOTOR_POLES = 4
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire drive_in_t         drv_in,
  input  wire pid_in_t           pid_in,
  input  wire logic              setpoint_ramp_bypass_input,
  output drive_out_t             drv_out,
  output pid_side_t              pid_side
);
  localparam int DIV_W = $clog2(TICK_CYCLES + 1);

  if (TICK_CYCLES < 2 || MOTOR_POLES < 2) begin : g_chk
    $error("pid_sleep_setpoint_dwell: TICK_CYCLES and MOTOR_POLES must be at least 2");
  end

  typedef struct packed {
    dwell_st_t        dw;
    cfg_t             cfg;
    status_t          stat;
    logic [15:0]      sp_target;
    logic [15:0]      sp_ramp;
    logic [31:0]      pid_err;
    drive_out_t       dout;
    logic [7:0]       dw_cnt;
    logic             start_done;
    logic             stop_done;
    logic [31:0]      sp_mon;
    logic [31:0]      ref_mon;
    logic [31:0]      fb_mon;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [1:0]       byp_sync;
    logic [DIV_W-1:0] div_cnt;
    logic             tick;
  } st_t;

  localparam st_t ST_RST = '{dw: DW_IDLE, cfg: CFG_RST, default: '0};

  st_t st;
  st_t nx;

  function automatic logic [15:0] sat16(input logic [15:0] v, input logic [15:0] mx);
    return (v > mx) ? mx : v;
  endfunction

  function automatic logic signed [31:0] pct_to_hz(input logic signed [31:0] pct,
                                                   input logic [15:0] maxf);
    logic signed [31:0] p;
    p = pct * $signed({16'h0000, maxf});
    return p / PCT_FULL;
  endfunction

  // Display value of a 0.01 % quantity in the selected unit
  function automatic logic [31:0] disp(input logic [15:0] pct, input logic [1:0] code,
                                       input logic [15:0] maxf, input logic [15:0] ufs);
    logic [63:0] w;
    w = 64'(pct);
    case (code)
      SC_HZ:   w = (64'(pct) * 64'(maxf)) / 64'(HZ_DISP_DIV);
      SC_PCT:  w = 64'(pct);
      SC_RPM:  w = (64'(pct) * 64'(maxf) * 64'(RPM_NUM)) / (64'(PCT_FULL) * 64'(MOTOR_POLES));
      SC_USER: w = (64'(pct) * 64'(ufs)) / 64'(PCT_FULL);
      default: w = 64'(pct);
    endcase
    return w[31:0];
  endfunction

  function automatic logic [15:0] ramp_toward(input logic [15:0] cur, input logic [15:0] tgt,
                                              input logic [15:0] step);
    if (tgt > cur) begin
      return (tgt - cur > step) ? cur + step : tgt;
    end
    return (cur - tgt > step) ? cur - step : tgt;
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return a inside {A_CTRL, A_SLEEP, A_FBH, A_SP, A_LIM, A_SCALE, A_DWS, A_DWP,
                     A_STATUS, A_SP_MON, A_REF_MON, A_FB_MON};
  endfunction

  cfg_t               c;
  logic               in_pid;
  logic               trim_mode;
  logic               rev_ok;
  logic               bypass;
  logic signed [31:0] fref32;
  logic signed [31:0] pid_raw;
  logic signed [31:0] clamp_pct;
  logic signed [31:0] pid_cl;
  logic signed [31:0] pid_hz;
  logic signed [31:0] adj_hz;
  logic signed [31:0] sense_hz;
  logic signed [31:0] lim_pct;
  logic signed [31:0] err_raw;
  logic signed [31:0] err_lim;
  logic [15:0]        tf_mag;
  logic [15:0]        ramp_step;
  logic [7:0]         ramp_den;
  logic               below_lvl;
  logic               above_lvl;
  logic               fb_above;
  logic               sleep_hit;
  logic               wake_hit;
  logic               fbh_hit;

  assign c         = st.cfg;
  assign bypass    = st.byp_sync[1];
  assign in_pid    = c.ctrl.process_control_mode != MODE_OFF;
  assign trim_mode = c.ctrl.process_control_mode inside {MODE_TRIM_A, MODE_TRIM_B};
  assign rev_ok    = c.ctrl.trim_negative_reverse_select && !c.ctrl.reverse_prohibit_select;
  assign fref32    = $signed({16'h0000, drv_in.freq_ref});
  assign pid_raw   = 32'($signed(pid_in.pid_out));
  assign clamp_pct = 32'($signed(c.lim.output_lower_clamp));
  assign pid_cl    = (clamp_pct != 0 && pid_raw < clamp_pct) ? clamp_pct : pid_raw;
  // Zero limit unless trim reversal is allowed and not prohibited
  assign pid_hz    = pct_to_hz((trim_mode && !rev_ok && pid_cl < 0) ? 32'sh0 : pid_cl,
                               c.scale.max_output_frequency);
  assign adj_hz    = !in_pid   ? fref32 :
                     trim_mode ? fref32 + pid_hz :
                     (pid_hz < 0) ? 32'sh0 : pid_hz;
  assign tf_mag    = (adj_hz < 0) ? 16'(-adj_hz) : 16'(adj_hz);
  // Watches the reference when control is off, so sleep never idles
  assign sense_hz  = in_pid ? ((pid_hz < 0) ? 32'sh0 : pid_hz) : fref32;
  assign below_lvl = sense_hz < $signed({16'h0000, c.sleep.sleep_level});
  assign above_lvl = sense_hz > $signed({16'h0000, c.sleep.sleep_level});
  assign fb_above  = pid_in.feedback > c.fbh.feedback_high_level;
  assign lim_pct   = $signed({16'h0000, c.lim.input_bipolar_clamp}) * INLIM_SCALE;
  assign err_raw   = $signed({16'h0000, st.sp_ramp}) - $signed({16'h0000, pid_in.feedback});
  assign err_lim   = (err_raw > lim_pct) ? lim_pct :
                     (err_raw < -lim_pct) ? -lim_pct : err_raw;
  assign ramp_den  = (c.sp.setpoint_ramp_time == '0) ? 8'h01 : c.sp.setpoint_ramp_time;
  assign ramp_step = (RAMP_STEP_NUM / ramp_den == 0) ? 16'h0001 : 16'(RAMP_STEP_NUM / ramp_den);

  hold_timer u_sleep_in (
    .core_clk (core_clk), .rst_n (rst_n), .tick (st.tick),
    .cond (below_lvl), .limit (c.sleep.sleep_delay), .expired (sleep_hit)
  );
  hold_timer u_wake (
    .core_clk (core_clk), .rst_n (rst_n), .tick (st.tick),
    .cond (above_lvl), .limit (c.sleep.sleep_delay), .expired (wake_hit)
  );
  hold_timer u_fbh (
    .core_clk (core_clk), .rst_n (rst_n), .tick (st.tick),
    .cond (fb_above), .limit (c.fbh.feedback_high_time), .expired (fbh_hit)
  );

  always_comb begin
    nx = st;
    if (st.div_cnt == DIV_W'(TICK_CYCLES - 1)) begin
      nx.div_cnt = '0;
      nx.tick    = 1'b1;
    end else begin
      nx.div_cnt = st.div_cnt + 1'b1;
      nx.tick    = 1'b0;
    end
    nx.byp_sync = {st.byp_sync[0], setpoint_ramp_bypass_input};

    // APB: one access cycle, answer prepared during setup
    nx.pready  = psel && !penable;
    nx.pslverr = psel && !penable && !addr_ok(paddr);
    if (psel && !penable) begin
      case (paddr)
        A_CTRL:    nx.prdata = 32'(c.ctrl);
        A_SLEEP:   nx.prdata = 32'(c.sleep);
        A_FBH:     nx.prdata = 32'(c.fbh);
        A_SP:      nx.prdata = 32'(c.sp);
        A_LIM:     nx.prdata = 32'(c.lim);
        A_SCALE:   nx.prdata = 32'(c.scale);
        A_DWS:     nx.prdata = 32'(c.dws);
        A_DWP:     nx.prdata = 32'(c.dwp);
        A_STATUS:  nx.prdata = 32'(st.stat);
        A_SP_MON:  nx.prdata = st.sp_mon;
        A_REF_MON: nx.prdata = st.ref_mon;
        A_FB_MON:  nx.prdata = st.fb_mon;
        default:   nx.prdata = '0;
      endcase
    end
    if (psel && penable && st.pready && pwrite) begin
      case (paddr)
        A_CTRL:  nx.cfg.ctrl = ctrl_t'(pwdata[$bits(ctrl_t)-1:0]);
        A_SLEEP: begin
          nx.cfg.sleep = sleep_t'(pwdata[$bits(sleep_t)-1:0]);
          nx.cfg.sleep.sleep_level = sat16(nx.cfg.sleep.sleep_level, LEVEL_MAX);
        end
        A_FBH: begin
          nx.cfg.fbh = fbh_t'(pwdata[$bits(fbh_t)-1:0]);
          nx.cfg.fbh.feedback_high_level = sat16(nx.cfg.fbh.feedback_high_level, PCT_MAX);
        end
        A_SP: begin
          nx.cfg.sp = sp_t'(pwdata[$bits(sp_t)-1:0]);
          nx.cfg.sp.internal_setpoint_value =
            sat16(nx.cfg.sp.internal_setpoint_value, PCT_MAX);
        end
        A_LIM: begin
          nx.cfg.lim = lim_t'(pwdata);
          nx.cfg.lim.input_bipolar_clamp = sat16(nx.cfg.lim.input_bipolar_clamp, PCT_MAX);
          if ($signed(nx.cfg.lim.output_lower_clamp) > $signed(PCT_MAX)) begin
            nx.cfg.lim.output_lower_clamp = PCT_MAX;
          end else if ($signed(nx.cfg.lim.output_lower_clamp) < -$signed(PCT_MAX)) begin
            nx.cfg.lim.output_lower_clamp = 16'(-$signed(PCT_MAX));
          end
        end
        A_SCALE: begin
          nx.cfg.scale = scale_t'(pwdata);
          nx.cfg.scale.user_full_scale_value =
            sat16(nx.cfg.scale.user_full_scale_value, UFS_MAX);
        end
        A_DWS: begin
          nx.cfg.dws = dws_t'(pwdata[$bits(dws_t)-1:0]);
          nx.cfg.dws.start_dwell_frequency = sat16(nx.cfg.dws.start_dwell_frequency, LEVEL_MAX);
          nx.cfg.dws.start_dwell_time = 8'(sat16(16'(nx.cfg.dws.start_dwell_time), DWELL_MAX));
        end
        A_DWP: begin
          nx.cfg.dwp = dwp_t'(pwdata[$bits(dwp_t)-1:0]);
          nx.cfg.dwp.stop_dwell_frequency = sat16(nx.cfg.dwp.stop_dwell_frequency, LEVEL_MAX);
          nx.cfg.dwp.stop_dwell_time = 8'(sat16(16'(nx.cfg.dwp.stop_dwell_time), DWELL_MAX));
        end
        default: ;
      endcase
    end

    if (!st.stat.sleeping && sleep_hit) begin
      nx.stat.sleeping = 1'b1;
    end else if (st.stat.sleeping && wake_hit) begin
      nx.stat.sleeping = 1'b0;
    end
    nx.stat.fb_high_loss = fbh_hit;

    // Setpoint source, then its own ramp ahead of the controller
    nx.sp_target = c.ctrl.setpoint_source_select ? c.sp.internal_setpoint_value
                                                 : pid_in.setpoint_ext;
    if (bypass || c.sp.setpoint_ramp_time == '0) begin
      nx.sp_ramp = st.sp_target;
    end else if (st.tick) begin
      nx.sp_ramp = ramp_toward(st.sp_ramp, st.sp_target, ramp_step);
    end
    nx.pid_err = err_lim;

    // Start hold is armed once per start from zero speed, stop hold once per acceleration
    if (!drv_in.accelerating && drv_in.ramp_freq == '0) begin
      nx.start_done = 1'b0;
    end
    if (drv_in.accelerating) begin
      nx.stop_done = 1'b0;
    end
    case (st.dw)
      DW_IDLE: begin
        nx.dw_cnt = '0;
        if (drv_in.accelerating && !st.start_done && c.dws.start_dwell_time != '0 &&
            drv_in.ramp_freq >= c.dws.start_dwell_frequency) begin
          nx.dw = DW_START;
        end else if (drv_in.decelerating && !st.stop_done && c.dwp.stop_dwell_time != '0 &&
                     drv_in.ramp_freq <= c.dwp.stop_dwell_frequency) begin
          nx.dw = DW_STOP;
        end
      end
      DW_START: begin
        if (st.dw_cnt >= c.dws.start_dwell_time) begin
          nx.dw         = DW_IDLE;
          nx.start_done = 1'b1;
        end else if (st.tick) begin
          nx.dw_cnt = st.dw_cnt + 1'b1;
        end
      end
      DW_STOP: begin
        if (st.dw_cnt >= c.dwp.stop_dwell_time) begin
          nx.dw        = DW_IDLE;
          nx.stop_done = 1'b1;
        end else if (st.tick) begin
          nx.dw_cnt = st.dw_cnt + 1'b1;
        end
      end
      default: nx.dw = DW_IDLE;
    endcase

    nx.dout.out_freq    = (nx.dw == DW_START) ? c.dws.start_dwell_frequency :
                          (nx.dw == DW_STOP)  ? c.dwp.stop_dwell_frequency  : drv_in.ramp_freq;
    nx.dout.hold_ramp   = nx.dw != DW_IDLE;
    nx.dout.run_enable  = drv_in.run_cmd && !nx.stat.sleeping;
    nx.dout.freq_target = nx.stat.sleeping ? 16'h0000 : tf_mag;
    nx.dout.reverse     = adj_hz < 0;
    nx.dout.stop_mode   = c.ctrl.stop_method_select;
    nx.stat.dwell_active = nx.dw != DW_IDLE;
    nx.stat.reverse      = nx.dout.reverse;

    nx.sp_mon  = disp(st.sp_ramp, c.ctrl.setpoint_scaling_code, c.scale.max_output_frequency,
                      c.scale.user_full_scale_value);
    nx.fb_mon  = disp(pid_in.feedback, c.ctrl.setpoint_scaling_code,
                      c.scale.max_output_frequency, c.scale.user_full_scale_value);
    nx.ref_mon = (in_pid && !c.ctrl.ref_monitor_content_select) ? 32'(tf_mag)
                                                                : 32'(drv_in.freq_ref);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RST;
    end else begin
      st <= nx;
    end
  end

  assign prdata   = st.prdata;
  assign pready   = st.pready;
  assign pslverr  = st.pslverr;
  assign drv_out  = st.dout;
  assign pid_side = '{pid_setpoint: st.sp_ramp, pid_error: st.pid_err};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_sleep_no_run: assert property (st.stat.sleeping |-> !drv_out.run_enable)
    else $error("run enabled while asleep");
  a_sleep_entry: assert property (!st.stat.sleeping && sleep_hit |=> st.stat.sleeping)
    else $error("sleep not entered after delay");
  a_sleep_wake: assert property (st.stat.sleeping && wake_hit |=> !st.stat.sleeping)
    else $error("sleep not left after delay");
  a_sleep_sense_off: assert property (
    !in_pid |-> below_lvl == (fref32 < $signed({16'h0000, c.sleep.sleep_level})))
    else $error("sleep detector idle with control off");
  a_stop_mode: assert property (##1 drv_out.stop_mode == $past(c.ctrl.stop_method_select))
    else $error("stop method not passed on");
  a_fbh_cause: assert property (st.stat.fb_high_loss |-> $past(fb_above, 2))
    else $error("feedback high flagged without cause");
  a_ramp_bypass: assert property (bypass |=> st.sp_ramp == $past(st.sp_target))
    else $error("setpoint ramp not bypassed");
  a_src_internal: assert property (c.ctrl.setpoint_source_select
    |=> st.sp_target == $past(c.sp.internal_setpoint_value))
    else $error("internal setpoint not selected");
  a_input_clamp: assert property (##1 $signed(st.pid_err) <= $past(lim_pct) &&
    $signed(st.pid_err) >= -$past(lim_pct))
    else $error("controller input outside limit");
  a_trim_zero: assert property (trim_mode && !rev_ok |=> !drv_out.reverse)
    else $error("reverse while zero limit selected");
  a_dwell_start: assert property (st.dw == DW_START |->
    drv_out.out_freq == $past(c.dws.start_dwell_frequency))
    else $error("start dwell frequency not held");
  a_dwell_stop: assert property (st.dw == DW_STOP |->
    drv_out.out_freq == $past(c.dwp.stop_dwell_frequency))
    else $error("stop dwell frequency not held");
  a_dwell_skip: assert property (st.dw == DW_IDLE && c.dws.start_dwell_time == '0 &&
    c.dwp.stop_dwell_time == '0 |=> st.dw == DW_IDLE)
    else $error("dwell entered with zero time");
endmodule

// ### test/ramp_model.sv
/*
  Ramp generator and output stage model on the drive side of the block.
  Assumes the block's clock and reset; the ramp moves one unit per clock.
*/
`timescale 1ns/1ps
module ramp_model
  import pid_sleep_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire drive_out_t  drv_out,
  input  wire logic [15:0] freq_ref,
  input  wire logic        run_cmd,
  output drive_in_t        drv_in
);
  logic [15:0] goal;
  assign goal = drv_out.run_enable ? drv_out.freq_target : 16'h0000;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_in <= '0;
    end else begin
      drv_in.freq_ref <= freq_ref;
      drv_in.run_cmd <= run_cmd;
      drv_in.accelerating <= drv_in.ramp_freq < goal;
      drv_in.decelerating <= drv_in.ramp_freq > goal;
      // A dwell hold freezes the ramp where it stands
      if (!drv_out.hold_ramp && drv_in.ramp_freq < goal) begin
        drv_in.ramp_freq <= drv_in.ramp_freq + 16'h0001;
      end else if (!drv_out.hold_ramp && drv_in.ramp_freq > goal) begin
        drv_in.ramp_freq <= drv_in.ramp_freq - 16'h0001;
      end
    end
  end
endmodule

// ### test/pid_sleep_setpoint_dwell_bench.sv
/*
  Self-checking bench: APB register access, sleep, setpoint, feedback-high,
  dwell holds, monitors and trim reversal.
  Assumes a 4-clock control tick so that delays stay short.
*/
`timescale 1ns/1ps
module pid_sleep_setpoint_dwell_bench
  import pid_sleep_pkg::*;
;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, byp;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] fref;
  logic run;
  pid_in_t pid_in;
  drive_in_t drv_in;
  drive_out_t drv_out;
  pid_side_t pid_side;
  int miscompares, samples_checked, i;
  pid_sleep_setpoint_dwell #(.TICK_CYCLES(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .drv_in(drv_in), .pid_in(pid_in),
    .setpoint_ramp_bypass_input(byp), .drv_out(drv_out), .pid_side(pid_side));
  ramp_model ramp_u (.core_clk(core_clk), .rst_n(rst_n), .drv_out(drv_out), .freq_ref(fref),
    .run_cmd(run), .drv_in(drv_in));
  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin miscompares++; print_verdict(); end
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wait_run(input logic v);
    for (i = 0; i < 80 && drv_out.run_enable !== v; i++) @(posedge core_clk);
    if (drv_out.run_enable !== v) begin miscompares++; print_verdict(); end
  endtask
  task automatic wait_hold(input logic v);
    for (i = 0; i < 400 && drv_out.hold_ramp !== v; i++) @(posedge core_clk);
    if (drv_out.hold_ramp !== v) begin miscompares++; print_verdict(); end
  endtask
  task automatic poll_fbh();
    for (i = 0; i < 20; i++) begin apb(1'b0, A_STATUS, 32'h0); if (rd[1] === 1'b1) break; end
    chk("fb_high_loss", {31'h0, rd[1]}, 32'h1);
  endtask
  initial begin core_clk = 1'b0; forever #25 core_clk = ~core_clk; end
  initial begin
    rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; byp = 0;
    fref = 16'h00c8; run = 1; pid_in = '0; miscompares = 0; samples_checked = 0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, A_CTRL, 32'h0); chk("ctrl reset", rd, 32'h0000_0480);
    apb(1'b0, A_FBH, 32'h0); chk("fbh reset", rd, 32'h000a_2710);
    apb(1'b0, 8'h40, 32'h0); chk("unmapped err", {31'h0, pslverr}, 32'h1);
    apb(1'b1, A_CTRL, 32'h0000_0490);
    apb(1'b0, A_CTRL, 32'h0); chk("ctrl rw", rd, 32'h0000_0490);
    chk("stop_mode", {30'h0, drv_out.stop_mode}, 32'h2);
    apb(1'b1, A_SLEEP, 32'h0002_0064);
    fref <= 16'h0032;
    repeat (8) @(posedge core_clk);
    chk("awake early", {31'h0, drv_out.run_enable}, 32'h1);
    wait_run(1'b0);
    chk("asleep target", {16'h0, drv_out.freq_target}, 32'h0);
    fref <= 16'h00c8;
    repeat (8) @(posedge core_clk);
    chk("asleep early", {31'h0, drv_out.run_enable}, 32'h0);
    wait_run(1'b1);
    byp <= 1'b1;
    apb(1'b1, A_SP, 32'h0013_880a);
    apb(1'b1, A_CTRL, 32'h0000_04c0);
    repeat (8) @(posedge core_clk);
    chk("pid_setpoint", {16'h0, pid_side.pid_setpoint}, 32'h1388);
    apb(1'b1, A_SP, 32'h00ff_ff00);
    apb(1'b0, A_SP, 32'h0); chk("sp saturate", rd, 32'h0027_1000);
    apb(1'b1, A_FBH, 32'h0001_1f40);
    pid_in.feedback <= 16'h2328;
    apb(1'b0, A_STATUS, 32'h0); chk("fbh early", {31'h0, rd[1]}, 32'h0);
    poll_fbh();
    // Stop method stays ramp-to-stop from here on, as dwell needs
    apb(1'b1, A_DWS, 32'h0002_012c);
    apb(1'b1, A_DWP, 32'h0002_00fa);
    fref <= 16'h0190;
    wait_hold(1'b1);
    chk("start dwell", {16'h0, drv_out.out_freq}, 32'h0000_012c);
    wait_hold(1'b0);
    // Two ticks of four clocks, give or take the tick phase
    chk("start dwell time", {31'h0, i >= 5 && i <= 10}, 32'h1);
    fref <= 16'h0096;
    wait_hold(1'b1);
    chk("stop dwell", {16'h0, drv_out.out_freq}, 32'h0000_00fa);
    byp <= 1'b0;
    apb(1'b1, A_SP, 32'h0000_000a);
    repeat (8) @(posedge core_clk);
    chk("sp ramp", {31'h0, pid_side.pid_setpoint inside {[16'h2329:16'h270f]}}, 32'h1);
    apb(1'b1, A_CTRL, 32'h0000_0440);
    apb(1'b0, A_FB_MON, 32'h0); chk("fb monitor", rd, 32'h0000_1518);
    pid_in.pid_out <= 16'he0c0;
    apb(1'b1, A_CTRL, 32'h0000_0443);
    apb(1'b0, A_REF_MON, 32'h0); chk("ref adjusted", rd, 32'h0000_014a);
    chk("trim reverse", {31'h0, drv_out.reverse}, 32'h1);
    apb(1'b1, A_CTRL, 32'h0000_0043);
    apb(1'b0, A_REF_MON, 32'h0); chk("ref zero limit", rd, 32'h0000_0096);
    chk("trim no reverse", {31'h0, drv_out.reverse}, 32'h0);
    print_verdict();
  end
endmodule
